// *** logic/spi_nv_map.svh ***
// Constants for the SPI nonvolatile memory slave.
// Function
// - Status bits 0, 4, 5 read zero, bit 6 reads one, never writable.
// - Write enable latch is status bit 1, cleared at power-up, one permits writes.
// - Status write clears the latch; set or clear command and a write also change it.
// - Block protect 00 none, 01 C000h-FFFFh, 10 8000h-FFFFh, 11 everything.
// - Block protect bits 2 and 3 are loaded with 00 at every reset, not retained.
// - Protect pin enable one with protect pin low rejects status writes.
// - Protect pin never guards the array; only latch and block bits do.
// - Status read opcode is answered by one byte of current status.
// - Status write needs the latch set and, with pin enable one, pin high; it clears the latch.
// - Write opcode, two address bytes MSB first, then data bytes stored in sequence.
// - Address counter wraps FFFFh to 0000h during writes and reads.
// - Each data byte is stored at its eighth bit, no buffering, never busy.
// - Burst write reaching a protected address stops counting and drops later bytes.
// - Chip select rising ends a write; only complete bytes are stored.
// - Read returns bytes from the next clock, ignoring input, until chip select rises.
// - Fast read adds one dummy byte after the address, then streams like read.
// - While driving read data the serial input is ignored.
// - Hold low with clock low pauses; hold high with clock low resumes.
// - Sleep opcode then chip select rising sleeps: output floats, only select watched.
// - Next select fall starts wakeup; output floats, commands may be ignored.
// - Opcodes 06h, 04h, 05h, 01h, 03h, 0Bh, 02h, B9h, 9Fh, sent MSB first; 9Fh is ignored here like an unknown opcode.
// - Latch clears at select rising after clear, status write or memory write.
// - Unknown opcode: input ignored and output floats until next select fall.
// - Clock level at select fall picks mode 0 or 3; in on rise, out on fall.
`ifndef SPI_NV_MAP_SVH
`define SPI_NV_MAP_SVH
`define OPC_SET_LATCH 8'h06
`define OPC_CLR_LATCH 8'h04
`define OPC_STATUS_RD 8'h05
`define OPC_STATUS_WR 8'h01
`define OPC_READ 8'h03
`define OPC_FAST_READ 8'h0B
`define OPC_WRITE 8'h02
`define OPC_SLEEP 8'hB9
`define OPC_IDENT_RD 8'h9F
`define SR_PIN_EN_POS 7
`define SR_BP_HIGH_POS 3
`define SR_BP_LOW_POS 2
`define LATCH_RST 1'b0
`define PIN_EN_RST 1'b0
`define BP_RST 2'h0
`define PROT_QUARTER 16'hC000
`define PROT_HALF 16'h8000
`define ADDR_LAST 16'hFFFF
`define MCLK_NS 40
`define WAKE_RECOVERY_NS 100000
`define WAKE_RECOVERY_CYC (`WAKE_RECOVERY_NS / `MCLK_NS)
`endif

// *** logic/spi_nv_pkg.sv ***
// Types shared by the SPI nonvolatile memory slave.
package spi_nv_pkg;
    typedef enum logic [2:0] {
        PH_OPC, PH_ADDR, PH_DUMMY, PH_WDATA,
        PH_RDATA, PH_SRD, PH_SRW, PH_IGN
    } phase_type;
    typedef enum logic [2:0] {
        EF_NONE, EF_SET, EF_CLR, EF_SR_WRITE, EF_SLEEP
    } effect_type;
    typedef enum logic [1:0] {PW_AWAKE, PW_ASLEEP, PW_WAKING} power_type;
    typedef struct packed {
        logic protect_pin_enable;
        logic block_protect_high;
        logic block_protect_low;
    } prot_cfg_type;
    typedef struct packed {
        logic awake;
        logic write_enable_latch;
        prot_cfg_type cfg;
    } link_view_type;
    typedef struct packed {
        phase_type ph;
        logic [2:0] bits;
        logic [7:0] sh;
        logic [15:0] addr;
        logic abyte;
        logic fast;
        logic wr;
        logic blocked;
        logic started;
        link_view_type m1;
        link_view_type m2;
    } link_state_type;
    typedef struct packed {
        effect_type kind;
        logic [7:0] data;
    } effect_cmd_type;
    typedef struct packed {
        logic drv;
        logic [7:0] osh;
    } out_state_type;
    typedef struct packed {
        logic [2:0] cs_s;
        logic [1:0] wp_s;
        logic write_enable_latch;
        prot_cfg_type cfg;
        power_type pw;
        logic [31:0] cnt;
    } sys_state_type;
endpackage

// *** logic/spi_nv_memory_slave.sv ***
// SPI slave command logic for a 64K x 8 nonvolatile byte memory.
`timescale 1ns/1ps
`default_nettype none
`include "spi_nv_map.svh"
module spi_nv_memory_slave #(
    parameter int WAKE_REC_CYC = `WAKE_RECOVERY_CYC
) (
    // System clock and reset
    input wire logic MCLK_I,
    input wire logic NRST_I,
    // Serial link from the bus master
    input wire logic SCK_I,
    input wire logic CS_N_I,
    input wire logic SI_I,
    input wire logic HOLD_N_I,
    input wire logic WP_N_I,
    // Serial output pin
    output logic SO_O,
    output logic SO_OE_N_O
);
    import spi_nv_pkg::*;

    // ==========================================================
    // Shared decoding
    // ==========================================================
    function automatic logic is_protected(
        input logic [15:0] a,
        input prot_cfg_type c
    );
        logic [1:0] bp;
        bp = {c.block_protect_high, c.block_protect_low};
        unique case (bp)
            2'b00: is_protected = 1'b0;
            2'b01: is_protected = (a >= `PROT_QUARTER);
            2'b10: is_protected = (a >= `PROT_HALF);
            2'b11: is_protected = 1'b1;
        endcase
    endfunction

    function automatic logic [7:0] status_byte(
        input logic latch,
        input prot_cfg_type c
    );
        status_byte = 8'h40;
        status_byte[`SR_PIN_EN_POS] = c.protect_pin_enable;
        status_byte[`SR_BP_HIGH_POS] = c.block_protect_high;
        status_byte[`SR_BP_LOW_POS] = c.block_protect_low;
        status_byte[1] = latch;
    endfunction

    // ==========================================================
    // Link domain: rising edges take input bits
    // ==========================================================
    link_state_type lq;
    link_state_type ln;
    effect_cmd_type eq;
    effect_cmd_type ed;
    out_state_type oq;
    out_state_type on;
    sys_state_type sq;
    sys_state_type sn;
    logic frame_rst_n;
    logic wr_en;
    logic [7:0] byte_in;
    logic [7:0] mem [0:65535];
    link_view_type view;

    // The frame logic restarts from constants whenever select is high.
    assign frame_rst_n = NRST_I & ~CS_N_I;

    always_comb begin
        view.awake = (sq.pw == PW_AWAKE);
        view.write_enable_latch = sq.write_enable_latch;
        view.cfg = sq.cfg;
    end

    always_comb begin
        ln = lq;
        ed = eq;
        wr_en = 1'b0;
        byte_in = {lq.sh[6:0], SI_I};
        ln.m1 = view;
        ln.m2 = lq.m1;
        if (HOLD_N_I) begin
            ln.started = 1'b1;
            if (!lq.started) begin
                ed.kind = EF_NONE;
                ed.data = 8'h00;
            end
            ln.sh = byte_in;
            ln.bits = lq.bits + 3'd1;
            if (lq.bits == 3'd7) begin
                unique case (lq.ph)
                    PH_OPC: begin
                        ln.ph = PH_IGN;
                        // Commands during wakeup are dropped.
                        if (lq.m2.awake) begin
                            unique case (byte_in)
                                `OPC_SET_LATCH: begin
                                    ed.kind = EF_SET;
                                end
                                `OPC_CLR_LATCH: begin
                                    ed.kind = EF_CLR;
                                end
                                `OPC_STATUS_RD: begin
                                    ln.ph = PH_SRD;
                                end
                                `OPC_STATUS_WR: begin
                                    ed.kind = EF_CLR;
                                    ln.ph = PH_SRW;
                                end
                                `OPC_READ: begin
                                    ln.ph = PH_ADDR;
                                end
                                `OPC_FAST_READ: begin
                                    ln.ph = PH_ADDR;
                                    ln.fast = 1'b1;
                                end
                                `OPC_WRITE: begin
                                    ln.ph = PH_ADDR;
                                    ln.wr = 1'b1;
                                    ed.kind = EF_CLR;
                                end
                                `OPC_SLEEP: begin
                                    ed.kind = EF_SLEEP;
                                end
                                // Identification is not served here.
                                default: begin
                                    ln.ph = PH_IGN;
                                end
                            endcase
                        end
                    end
                    PH_ADDR: begin
                        ln.addr = {lq.addr[7:0], byte_in};
                        ln.abyte = 1'b1;
                        if (lq.abyte) begin
                            if (lq.wr) begin
                                ln.ph = PH_WDATA;
                            end else if (lq.fast) begin
                                ln.ph = PH_DUMMY;
                            end else begin
                                ln.ph = PH_RDATA;
                            end
                        end
                    end
                    PH_DUMMY: begin
                        ln.ph = PH_RDATA;
                    end
                    PH_WDATA: begin
                        // The pin plays no part in array writes.
                        if (!lq.blocked && lq.m2.write_enable_latch &&
                            !is_protected(lq.addr, lq.m2.cfg)) begin
                            wr_en = 1'b1;
                            ln.addr = lq.addr + 16'h0001;
                        end else begin
                            ln.blocked = 1'b1;
                        end
                    end
                    PH_RDATA: begin
                        // Input bits are shifted but never decoded here.
                        ln.addr = lq.addr + 16'h0001;
                    end
                    PH_SRD: begin
                        ln.ph = PH_IGN;
                    end
                    PH_SRW: begin
                        ed.kind = EF_SR_WRITE;
                        ed.data = byte_in;
                        ln.ph = PH_IGN;
                    end
                    PH_IGN: begin
                        ln.ph = PH_IGN;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge SCK_I or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            lq <= '0;
        end else begin
            lq <= ln;
        end
    end

    // The effect survives select going high so the system side can act.
    always_ff @(posedge SCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            eq <= '0;
        end else begin
            eq <= ed;
        end
    end

    // Array contents have no reset; they model retained storage.
    always_ff @(posedge SCK_I) begin
        if (wr_en) begin
            mem[lq.addr] <= byte_in;
        end
    end

    // ==========================================================
    // Link domain: falling edges move output bits
    // ==========================================================
    always_comb begin
        on = oq;
        if (HOLD_N_I) begin
            // Falls before the first rise see PH_OPC and do nothing,
            // which serves mode 0 and mode 3 alike.
            if (lq.ph == PH_RDATA || lq.ph == PH_SRD) begin
                if (lq.bits == 3'd0) begin
                    on.drv = 1'b1;
                    if (lq.ph == PH_SRD) begin
                        on.osh = status_byte(lq.m2.write_enable_latch,
                            lq.m2.cfg);
                    end else begin
                        on.osh = mem[lq.addr];
                    end
                end else begin
                    on.osh = {oq.osh[6:0], 1'b0};
                end
            end else begin
                on.drv = 1'b0;
            end
        end
    end

    always_ff @(negedge SCK_I or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            oq <= '0;
        end else begin
            oq <= on;
        end
    end

    assign SO_O = oq.osh[7];
    // Hold floats the pin at once without disturbing the shift state.
    assign SO_OE_N_O = ~(oq.drv & HOLD_N_I);

    // ==========================================================
    // System domain: latch, protection, sleep and wakeup
    // ==========================================================
    logic cs_rise;
    logic cs_fall;

    assign cs_rise = sq.cs_s[1] & ~sq.cs_s[2];
    assign cs_fall = ~sq.cs_s[1] & sq.cs_s[2];

    // The effect is read only after a synchronised select rise; it was
    // last written inside the frame and cannot change until the next
    // frame's first clock, so select must stay high for three clocks.
    always_comb begin
        sn = sq;
        sn.cs_s = {sq.cs_s[1:0], CS_N_I};
        sn.wp_s = {sq.wp_s[0], WP_N_I};
        if (cs_rise) begin
            unique case (eq.kind)
                EF_SET: begin
                    sn.write_enable_latch = 1'b1;
                end
                EF_CLR: begin
                    sn.write_enable_latch = 1'b0;
                end
                EF_SR_WRITE: begin
                    if (sq.write_enable_latch &&
                        !(sq.cfg.protect_pin_enable && !sq.wp_s[1])) begin
                        sn.cfg.protect_pin_enable =
                            eq.data[`SR_PIN_EN_POS];
                        sn.cfg.block_protect_high =
                            eq.data[`SR_BP_HIGH_POS];
                        sn.cfg.block_protect_low =
                            eq.data[`SR_BP_LOW_POS];
                    end
                    sn.write_enable_latch = 1'b0;
                end
                EF_SLEEP: begin
                    sn.pw = PW_ASLEEP;
                end
                EF_NONE: begin
                    sn.pw = sq.pw;
                end
                default: begin
                    sn.pw = sq.pw;
                end
            endcase
        end
        unique case (sq.pw)
            PW_AWAKE: begin
                sn.cnt = 32'h0000_0000;
            end
            PW_ASLEEP: begin
                if (cs_fall) begin
                    sn.pw = PW_WAKING;
                    sn.cnt = 32'h0000_0000;
                end
            end
            PW_WAKING: begin
                if (sq.cnt == 32'(WAKE_REC_CYC - 1)) begin
                    sn.pw = PW_AWAKE;
                end else begin
                    sn.cnt = sq.cnt + 32'h0000_0001;
                end
            end
            default: begin
                sn.pw = PW_AWAKE;
            end
        endcase
    end

    // Protection bits start at their shipped values on every reset.
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sq.cs_s <= 3'h7;
            sq.wp_s <= 2'h3;
            sq.write_enable_latch <= `LATCH_RST;
            sq.cfg.protect_pin_enable <= `PIN_EN_RST;
            sq.cfg.block_protect_high <= 1'(`BP_RST >> 1);
            sq.cfg.block_protect_low <= 1'(`BP_RST);
            sq.pw <= PW_AWAKE;
            sq.cnt <= 32'h0000_0000;
        end else begin
            sq <= sn;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    AST_STATUS_FIXED: assert property (
        @(negedge SCK_I) disable iff (!frame_rst_n)
        (HOLD_N_I && lq.ph == PH_SRD && lq.bits == 3'd0)
        |=> (oq.osh[6:4] == 3'b100 && oq.osh[0] == 1'b0 && oq.drv))
        else $error("status fixed bits wrong");

    AST_LATCH_CLEAR: assert property (
        @(posedge MCLK_I) disable iff (!NRST_I)
        (cs_rise && (eq.kind == EF_CLR || eq.kind == EF_SR_WRITE))
        |=> !sq.write_enable_latch)
        else $error("latch not cleared at select rise");

    AST_LATCH_SET: assert property (
        @(posedge MCLK_I) disable iff (!NRST_I)
        !sq.write_enable_latch && !(cs_rise && eq.kind == EF_SET)
        |=> !sq.write_enable_latch)
        else $error("latch set without set command");

    AST_PIN_BLOCKS: assert property (
        @(posedge MCLK_I) disable iff (!NRST_I)
        (cs_rise && eq.kind == EF_SR_WRITE &&
         sq.cfg.protect_pin_enable && !sq.wp_s[1])
        |=> $stable(sq.cfg))
        else $error("status written while pin protects it");

    AST_NO_PROT_WRITE: assert property (
        @(posedge SCK_I) disable iff (!frame_rst_n)
        wr_en |-> (lq.m2.write_enable_latch && !lq.blocked &&
        !is_protected(lq.addr, lq.m2.cfg)))
        else $error("write into protected block");

    AST_ADDR_WRAP: assert property (
        @(posedge SCK_I) disable iff (!frame_rst_n)
        (HOLD_N_I && lq.ph == PH_RDATA && lq.bits == 3'd7 &&
         lq.addr == `ADDR_LAST) |=> (lq.addr == 16'h0000))
        else $error("address did not wrap");

    AST_SLEEP_ENTRY: assert property (
        @(posedge MCLK_I) disable iff (!NRST_I)
        (cs_rise && eq.kind == EF_SLEEP) |=> (sq.pw == PW_ASLEEP))
        else $error("sleep not entered");

    AST_WAKE_END: assert property (
        @(posedge MCLK_I) disable iff (!NRST_I)
        (sq.pw == PW_WAKING && sq.cnt == 32'(WAKE_REC_CYC - 1))
        |=> (sq.pw == PW_AWAKE))
        else $error("wakeup did not finish in time");

    AST_ASLEEP_IGNORED: assert property (
        @(posedge SCK_I) disable iff (!frame_rst_n)
        (HOLD_N_I && lq.ph == PH_OPC && lq.bits == 3'd7 &&
         !lq.m2.awake) |=> (lq.ph == PH_IGN && eq.kind == EF_NONE))
        else $error("command accepted while not awake");

endmodule // spi_nv_memory_slave
`default_nettype wire

// *** verif/spi_master_model.sv ***
// Serial bus master model that drives command frames into the slave.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Master model
module spi_master_model (
    // Serial link pins
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic hold_n_o,
    output logic wp_n_o,
    // Slave answer
    input wire logic so_i,
    input wire logic so_oe_n_i
);
    logic mode3 = 1'b0;
    int hold_at = -1;
    int oe_seen = 0;
    logic hold_oe = 1'b0;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        hold_n_o = 1'b1;
        wp_n_o = 1'b1;
    end
    // The clock only runs inside a frame; each frame adds a 7 ns offset,
    // so its edges drift against the system clock edges and can meet them.
    task automatic frame(input logic [7:0] tx[$], input int nrx,
            input int tail, output logic [7:0] rx[$]);
        int nb;
        int nt;
        logic [7:0] sh;
        nt = 8 * tx.size();
        nb = nt + 8 * nrx + tail;
        rx = {};
        sh = 8'h00;
        oe_seen = 0;
        sck_o = mode3;
        #7;
        cs_n_o = 1'b0;
        #40;
        for (int i = 0; i < nb; i++) begin
            sck_o = 1'b0;
            if (i < nt) begin
                si_o = tx[i / 8][7 - i % 8];
            end else begin
                si_o = ~si_o;
            end
            if (i == hold_at) begin
                #10;
                hold_n_o = 1'b0;
                repeat (2) begin
                    #40 sck_o = 1'b1;
                    si_o = ~si_o;
                    #40 sck_o = 1'b0;
                end
                // Release the pause well after the falling edge, not on it.
                #10;
                hold_oe = so_oe_n_i;
                hold_n_o = 1'b1;
            end
            #40;
            sck_o = 1'b1;
            if (so_oe_n_i === 1'b0) begin
                oe_seen++;
            end
            sh = {sh[6:0], so_i};
            if (i >= nt && i % 8 == 7 && i < nt + 8 * nrx) begin
                rx.push_back(sh);
            end
            #40;
        end
        sck_o = mode3;
        #40;
        cs_n_o = 1'b1;
        si_o = ~si_o;
        #200;
    endtask
endmodule // spi_master_model
`default_nettype wire

// *** verif/spi_nv_memory_slave_test.sv ***
// Self-checking testbench for the SPI memory slave.
`timescale 1ns/1ps
`default_nettype none
`include "spi_nv_map.svh"
// ==========================================================
// Bench top
module spi_nv_memory_slave_test;
    localparam int WREC = 20;
    logic mclk = 1'b0;
    logic nrst_n = 1'b0;
    wire logic sck, cs_n, si, hold_n, wp_n, so, so_oe_n;
    int bad_count = 0;
    int compares = 0;
    always #20 mclk = ~mclk;
    spi_nv_memory_slave #(.WAKE_REC_CYC(WREC)) u_spi_nv_memory_slave (
        .MCLK_I(mclk), .NRST_I(nrst_n), .SCK_I(sck), .CS_N_I(cs_n),
        .SI_I(si), .HOLD_N_I(hold_n), .WP_N_I(wp_n), .SO_O(so),
        .SO_OE_N_O(so_oe_n));
    spi_master_model u_spi_master_model (.sck_o(sck), .cs_n_o(cs_n),
        .si_o(si), .hold_n_o(hold_n), .wp_n_o(wp_n), .so_i(so),
        .so_oe_n_i(so_oe_n));
    task automatic tally_and_finish;
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] tx[$], input int nrx);
        logic [7:0] rx[$];
        u_spi_master_model.frame(tx, nrx, 0, rx);
    endtask
    task automatic status_is(input logic [7:0] e);
        logic [7:0] rx[$];
        u_spi_master_model.frame({`OPC_STATUS_RD}, 1, 0, rx);
        check8(rx[0], e);
    endtask
    task automatic status_wr(input logic [7:0] v);
        cmd({`OPC_SET_LATCH}, 0);
        cmd({`OPC_STATUS_WR, v}, 0);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d[$],
            input int tail, input logic latch);
        logic [7:0] rx[$];
        if (latch) begin
            cmd({`OPC_SET_LATCH}, 0);
        end
        u_spi_master_model.frame({`OPC_WRITE, a[15:8], a[7:0], d}, 0,
            tail, rx);
    endtask
    task automatic check_rd(input logic [7:0] op, input logic [15:0] a,
            input logic [7:0] e[$]);
        logic [7:0] tx[$];
        logic [7:0] rx[$];
        tx = {op, a[15:8], a[7:0]};
        if (op == `OPC_FAST_READ) begin
            tx.push_back(8'hA5);
        end
        u_spi_master_model.frame(tx, e.size(), 0, rx);
        foreach (e[i]) begin
            check8(rx[i], e[i]);
        end
    endtask
    // A hang in the design must still end the run with a verdict.
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        logic [15:0] pr[3];
        logic [7:0] ex[3];
        logic [7:0] v;
        logic prot;
        pr = '{16'h7FFF, 16'h8000, 16'hC000};
        repeat (4) @(negedge mclk);
        nrst_n = 1'b1;
        repeat (4) @(negedge mclk);
        status_is(8'h40);
        wr(16'hFFFF, {8'hA1, 8'hB2, 8'hC3, 8'hD4}, 0, 1'b1);
        status_is(8'h40);
        wr(16'h0001, {8'h5C}, 4, 1'b1);
        check_rd(`OPC_READ, 16'hFFFF, {8'hA1, 8'hB2, 8'h5C, 8'hD4});
        check_rd(`OPC_FAST_READ, 16'hFFFF, {8'hA1, 8'hB2, 8'h5C});
        wr(16'h0000, {8'h00}, 0, 1'b0);
        check_rd(`OPC_READ, 16'h0000, {8'hB2});
        cmd({`OPC_SET_LATCH}, 0);
        status_is(8'h42);
        cmd({`OPC_CLR_LATCH}, 0);
        status_is(8'h40);
        u_spi_master_model.hold_at = 28;
        check_rd(`OPC_READ, 16'hFFFF, {8'hA1, 8'hB2});
        u_spi_master_model.hold_at = -1;
        check1(u_spi_master_model.hold_oe, 1'b1);
        u_spi_master_model.mode3 = 1'b1;
        cmd({`OPC_SET_LATCH}, 0);
        status_is(8'h42);
        cmd({`OPC_CLR_LATCH}, 0);
        u_spi_master_model.mode3 = 1'b0;
        status_wr(8'hFF);
        status_is(8'hCC);
        u_spi_master_model.wp_n_o = 1'b0;
        status_wr(8'h00);
        status_is(8'hCC);
        u_spi_master_model.wp_n_o = 1'b1;
        status_wr(8'h84);
        status_is(8'hC4);
        u_spi_master_model.wp_n_o = 1'b0;
        wr(16'h0000, {8'h11}, 0, 1'b1);
        wr(16'hFFFF, {8'h77, 8'h88}, 0, 1'b1);
        check_rd(`OPC_READ, 16'hFFFF, {8'hA1, 8'h11});
        u_spi_master_model.wp_n_o = 1'b1;
        for (int bp = 0; bp < 4; bp++) begin
            status_wr({4'h0, bp[1:0], 2'b00});
            status_is({4'h4, bp[1:0], 2'b00});
            for (int k = 0; k < 3; k++) begin
                v = {bp[1:0], k[1:0], 4'h5};
                prot = (bp == 3) || (bp == 2 && pr[k][15]) ||
                    (bp == 1 && pr[k][15:14] == 2'b11);
                wr(pr[k], {v}, 0, 1'b1);
                ex[k] = prot ? ex[k] : v;
                check_rd(`OPC_READ, pr[k], {ex[k]});
            end
        end
        cmd({`OPC_IDENT_RD}, 2);
        check1(u_spi_master_model.oe_seen == 0, 1'b1);
        cmd({`OPC_SLEEP}, 0);
        cmd({`OPC_STATUS_RD}, 1);
        check1(u_spi_master_model.oe_seen == 0, 1'b1);
        repeat (WREC) @(negedge mclk);
        status_is(8'h4C);
        tally_and_finish();
    end
endmodule // spi_nv_memory_slave_test
`default_nettype wire
